/* hw/tatr_pkg.sv */
package tatr_pkg;

  // transaction speed of the link
  typedef enum logic [1:0] {
    TATR_FS,
    TATR_LS,
    TATR_HS
  } tatr_speed_t;

  localparam int TATR_CNT_W = 10;

  // turn-around limits in bit times; the real figures belong to the phy
  // layer, so these are plain defaults to be overridden per product
  localparam logic [TATR_CNT_W-1:0] TATR_TURN_FS_BITS = 10'h012;
  localparam logic [TATR_CNT_W-1:0] TATR_TURN_LS_BITS = 10'h012;
  localparam logic [TATR_CNT_W-1:0] TATR_TURN_HS_BITS = 10'h2e0;

  // bit times with no transition that mark a stuck bus; one more than the
  // worst-case six-bit stuff spacing so live data never looks stuck
  localparam logic [3:0] TATR_QUIET_BITS = 4'h7;

endpackage : tatr_pkg

/* hw/tatr_turnaround.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - errors shown only by missing acknowledgement
// - fs/ls timer: eop end to sop
// - hs timer: squelch entry to exit
// - no response before limit: transmission failed
// - device times token-data and data-handshake gaps
// - corrupted data: no response, await token
// - awaited handshake missing: end by timeout
// - false eop never causes a collision
// - false eop seen as crc failure
// - fs/ls stuck bus at frame end: loa
// - fs/ls activity past frame end: babble
// - hs unsquelched at microframe end: babble
// - offending port disabled at frame end
module tatr_turnaround #(
  parameter logic [tatr_pkg::TATR_CNT_W-1:0] TURN_FS =
    tatr_pkg::TATR_TURN_FS_BITS,
  parameter logic [tatr_pkg::TATR_CNT_W-1:0] TURN_LS =
    tatr_pkg::TATR_TURN_LS_BITS,
  parameter logic [tatr_pkg::TATR_CNT_W-1:0] TURN_HS =
    tatr_pkg::TATR_TURN_HS_BITS
) (
  input wire logic clk,                       // 50 MHz
  input wire logic reset_n,                   // async, active low
  input wire logic dPlusIn,                   // d+ pin level
  input wire logic dMinusIn,                  // d- pin level
  input wire logic squelchIn,                 // hs lines at squelch
  input wire tatr_pkg::tatr_speed_t speedSel, // transaction speed
  input wire logic bitTick,                   // one per bit time
  input wire logic armTurn,                   // expect a response next
  input wire logic rxCrcBad,                  // data packet corrupted
  input wire logic tokenSeen,                 // valid token received
  input wire logic hsReq,                     // engine wants handshake
  input wire logic frameEnd,                  // (micro)frame boundary
  input wire logic portEnable,                // re-enable the port
  output logic respStart,                     // response began
  output logic respTimeout,                   // turn-around expired
  output logic timerBusy,                     // timer counting
  output logic respSuppress,                  // hold all responses
  output logic hsGo,                          // send the handshake
  output logic babbleDet,                     // babble at frame end
  output logic loaDet,                        // loss of activity
  output logic portDisable                    // port shut off
);
  import tatr_pkg::*;

  typedef enum logic [1:0] {TA_IDLE, TA_ARMED, TA_TIMING} tatr_state_t;

  function automatic logic isJ(input logic dp, input logic dm,
                               input logic ls);
    isJ = ls ? (!dp && dm) : (dp && !dm);
  endfunction : isJ

  function automatic logic isK(input logic dp, input logic dm,
                               input logic ls);
    isK = ls ? (dp && !dm) : (!dp && dm);
  endfunction : isK

  logic dpS1_q, dpS2_q, dpP_q;
  logic dmS1_q, dmS2_q, dmP_q;
  logic sqS1_q, sqS2_q, sqP_q;
  tatr_state_t state_q, state_d;
  logic [TATR_CNT_W-1:0] cnt_q, cnt_d;
  logic [3:0] quiet_q;
  logic inPkt_q;
  logic busy_q;
  logic respStart_q, respTimeout_q, suppress_q, hsGo_q;
  logic babble_q, loa_q, portOff_q;

  // pins cross in through two stages; the third stage is the edge history
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // history starts at fs/hs idle j (ls k), so release shows no false eop edge
      {dpS1_q, dpS2_q, dpP_q} <= 3'h7;
      {dmS1_q, dmS2_q, dmP_q} <= 3'h0;
      {sqS1_q, sqS2_q, sqP_q} <= 3'h7;
    end else begin
      {dpS1_q, dpS2_q, dpP_q} <= {dPlusIn, dpS1_q, dpS2_q};
      {dmS1_q, dmS2_q, dmP_q} <= {dMinusIn, dmS1_q, dmS2_q};
      {sqS1_q, sqS2_q, sqP_q} <= {squelchIn, sqS1_q, sqS2_q};
    end
  end

  wire logic lowSpd = (speedSel == TATR_LS);
  wire logic highSpd = (speedSel == TATR_HS);
  wire logic se0Prev = !dpP_q && !dmP_q;
  wire logic se0Now = !dpS2_q && !dmS2_q;
  wire logic jPrev = isJ(dpP_q, dmP_q, lowSpd);
  wire logic jNow = isJ(dpS2_q, dmS2_q, lowSpd);
  wire logic kNow = isK(dpS2_q, dmS2_q, lowSpd);
  wire logic eopEdge = se0Prev && jNow;
  wire logic sopEdge = jPrev && kNow;
  wire logic sqEnter = sqS2_q && !sqP_q;
  wire logic sqLeave = !sqS2_q && sqP_q;
  wire logic endEdge = highSpd ? sqEnter : eopEdge;
  wire logic startEdge = highSpd ? sqLeave : sopEdge;
  wire logic lineMoved = (dpS2_q != dpP_q) || (dmS2_q != dmP_q);
  wire logic [TATR_CNT_W-1:0] turnLimit =
    highSpd ? TURN_HS : (lowSpd ? TURN_LS : TURN_FS);
  wire logic [TATR_CNT_W-1:0] cntNext = cnt_q + 10'h001;
  wire logic timedOut = bitTick && (cntNext >= turnLimit);

  // one timer serves both gaps: the engine arms it after token->data and
  // after data->handshake; start and stop follow the line itself
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      TA_IDLE: begin
        if (armTurn) begin
          state_d = TA_ARMED;
        end
      end
      TA_ARMED: begin
        if (endEdge) begin
          state_d = TA_TIMING;
          cnt_d = '0;
        end
      end
      TA_TIMING: begin
        if (startEdge) begin
          state_d = TA_IDLE;
        end else if (timedOut) begin
          state_d = TA_IDLE;
        end else if (bitTick) begin
          cnt_d = cntNext;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= TA_IDLE;
      cnt_q <= '0;
      respStart_q <= 1'b0;
      respTimeout_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      busy_q <= (state_d == TA_TIMING);
      respStart_q <= (state_q == TA_TIMING) && startEdge;
      respTimeout_q <= (state_q == TA_TIMING) && !startEdge && timedOut;
    end
  end

  // a corrupted packet gets no answer at all; a false eop may still have
  // the far end talking, so staying silent until a token avoids collision
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      suppress_q <= 1'b0;
      hsGo_q <= 1'b0;
    end else begin
      suppress_q <= rxCrcBad || (suppress_q && !tokenSeen);
      hsGo_q <= hsReq && !suppress_q && !rxCrcBad;
    end
  end

  // frame-end watchdog for a packet still in flight
  wire logic stuck = (quiet_q == TATR_QUIET_BITS) && !se0Now;
  wire logic hsBad = highSpd && !sqS2_q;
  wire logic fsLoa = !highSpd && inPkt_q && stuck;
  wire logic fsBabble = !highSpd && inPkt_q && !stuck;
  wire logic offend = frameEnd && (hsBad || fsLoa || fsBabble);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      inPkt_q <= 1'b0;
      quiet_q <= '0;
      babble_q <= 1'b0;
      loa_q <= 1'b0;
      portOff_q <= 1'b0;
    end else begin
      if (sopEdge && !highSpd) begin
        inPkt_q <= 1'b1;
      end else if (eopEdge || highSpd) begin
        inPkt_q <= 1'b0;
      end
      if (lineMoved) begin
        quiet_q <= '0;
      end else if (bitTick && quiet_q != TATR_QUIET_BITS) begin
        quiet_q <= quiet_q + 4'h1;
      end
      babble_q <= frameEnd && (hsBad || fsBabble);
      loa_q <= frameEnd && fsLoa;
      // set beats a simultaneous re-enable
      portOff_q <= offend || (portOff_q && !portEnable);
    end
  end

  assign respStart = respStart_q;
  assign respTimeout = respTimeout_q;
  assign timerBusy = busy_q;
  assign respSuppress = suppress_q;
  assign hsGo = hsGo_q;
  assign babbleDet = babble_q;
  assign loaDet = loa_q;
  assign portDisable = portOff_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_timer_start_eop: assert property (
    (state_q == TA_ARMED && !highSpd && eopEdge) |=> timerBusy && cnt_q == 0)
    else $error("fs/ls timer did not start on eop end");
  a_timer_start_sq: assert property (
    (state_q == TA_ARMED && highSpd && sqEnter) |=> timerBusy)
    else $error("hs timer did not start on squelch entry");
  a_resp_stop: assert property (
    (timerBusy && startEdge) |=> respStart && !timerBusy)
    else $error("response start not flagged");
  a_timeout_fire: assert property (
    (timerBusy && !startEdge && bitTick && cnt_q + 1 >= turnLimit)
    |=> respTimeout && !timerBusy)
    else $error("timeout missed at limit");
  a_no_early_to: assert property (
    respTimeout |-> $past(cnt_q) + 1 >= $past(turnLimit))
    else $error("timeout before limit");
  a_silent_bad: assert property (
    rxCrcBad |=> respSuppress && !hsGo)
    else $error("response after corrupted packet");
  a_hold_till_tok: assert property (
    (respSuppress && !tokenSeen && !rxCrcBad) |=> respSuppress)
    else $error("suppress dropped without token");
  a_hs_babble: assert property (
    (frameEnd && highSpd && !sqS2_q)
    |=> babbleDet ##1 (portDisable || $past(portEnable)))
    else $error("hs babble not caught");
  a_fs_loa: assert property (
    (frameEnd && !highSpd && inPkt_q && stuck) |=> loaDet && !babbleDet)
    else $error("loa not classed");
  a_port_off: assert property (
    (frameEnd && (hsBad || fsLoa || fsBabble))
    |=> portDisable ##1 (portDisable || $past(portEnable)))
    else $error("port not disabled");

  c_resp_ok: cover property (timerBusy ##[1:40] respStart);
  c_timeout: cover property (respTimeout);
  c_bad_then_tok: cover property (rxCrcBad ##[1:60] tokenSeen);
  c_babble: cover property (babbleDet);
endmodule : tatr_turnaround
`default_nettype wire

/* testbench/bus_turnaround_error_recovery_test.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin nFail++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module bus_turnaround_error_recovery_test;
  import tatr_pkg::*;
  localparam logic [9:0] TURN = 10'h004;
  logic clk, reset_n, bitTick, armTurn, rxCrcBad, tokenSeen, hsReq;
  logic frameEnd, portEnable, respStart, respTimeout, timerBusy;
  logic respSuppress, hsGo, babbleDet, loaDet, portDisable;
  wire logic dP, dM, sqOut;
  tatr_speed_t speedSel;
  int nFail, nChecks;
  tatr_host_model u_host (.clk(clk), .lowSpeed(speedSel == TATR_LS),
    .dPlus(dP), .dMinus(dM), .squelch(sqOut));
  tatr_turnaround #(.TURN_FS(TURN), .TURN_LS(TURN), .TURN_HS(TURN)) u_dut (
    .clk(clk), .reset_n(reset_n), .dPlusIn(dP), .dMinusIn(dM),
    .squelchIn(sqOut), .speedSel(speedSel), .bitTick(bitTick),
    .armTurn(armTurn), .rxCrcBad(rxCrcBad), .tokenSeen(tokenSeen),
    .hsReq(hsReq), .frameEnd(frameEnd), .portEnable(portEnable),
    .respStart(respStart), .respTimeout(respTimeout),
    .timerBusy(timerBusy), .respSuppress(respSuppress), .hsGo(hsGo),
    .babbleDet(babbleDet), .loaDet(loaDet), .portDisable(portDisable));
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  // pulse outputs are looked for once per clock, at each falling edge
  task automatic seen(ref logic s, input int n, output logic hit);
    hit = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (s === 1'b1) hit = 1'b1;
    end
  endtask : seen
  task automatic t_timeout();
    int c;
    c = 0;
    speedSel = TATR_FS;
    bitTick = 1'b1;
    pulse(armTurn);
    u_host.line(0, 2);
    u_host.line(1, 0);
    repeat (8) if (timerBusy !== 1'b1) @(negedge clk);
    `CHK("busy", 1'b1, timerBusy)
    while (respTimeout !== 1'b1 && c < 20) begin
      @(negedge clk);
      c++;
    end
    `CHK("tmoCyc", 1'b1, c >= TURN && c <= TURN + 1)
    @(negedge clk);
    `CHK("tmoOne", 1'b0, respTimeout)
    u_host.token_gap(1'b0, 1'b0, TURN);
    $display("test timeout done");
  endtask : t_timeout
  task automatic t_start(input tatr_speed_t sp);
    logic hit;
    logic hs;
    hs = (sp == TATR_HS);
    bitTick = 1'b0;
    speedSel = sp;
    pulse(armTurn);
    if (hs) begin
      u_host.sq(1'b0, 3);
      u_host.sq(1'b1, 4);
      u_host.sq(1'b0, 0);
    end else begin
      u_host.line(0, 2);
      u_host.line(1, 4);
      u_host.line(2, 0);
    end
    seen(respStart, 8, hit);
    `CHK("start", 1'b1, hit)
    `CHK("noTmo", 1'b0, respTimeout)
    u_host.sq(1'b1, 0);
    u_host.line(1, 4);
    $display("test start %0d done", sp);
  endtask : t_start
  task automatic t_suppress();
    logic hit;
    speedSel = TATR_FS;
    pulse(rxCrcBad);
    `CHK("supOn", 1'b1, respSuppress)
    fork
      pulse(hsReq);
      seen(hsGo, 3, hit);
    join
    `CHK("hsHeld", 1'b0, hit)
    u_host.token_gap(1'b1, 1'b0, 2);
    pulse(tokenSeen);
    @(negedge clk);
    `CHK("supOff", 1'b0, respSuppress)
    pulse(hsReq);
    `CHK("hsGo", 1'b1, hsGo)
    $display("test suppress done");
  endtask : t_suppress
  task automatic t_frame();
    logic hit;
    speedSel = TATR_HS;
    u_host.sq(1'b0, 2);
    pulse(frameEnd);
    `CHK("hsBab", 1'b1, babbleDet)
    `CHK("portOff", 1'b1, portDisable)
    u_host.sq(1'b1, 2);
    u_host.token_gap(1'b1, 1'b1, 0);
    pulse(portEnable);
    @(negedge clk);
    `CHK("portOn", 1'b0, portDisable)
    speedSel = TATR_FS;
    bitTick = 1'b1;
    u_host.line(2, 12);
    pulse(frameEnd);
    `CHK("loa", 1'b1, loaDet)
    u_host.line(0, 2);
    u_host.line(1, 4);
    for (int i = 0; i < 10; i++) u_host.line(2 - i % 2, 0);
    fork
      pulse(frameEnd);
      seen(babbleDet, 3, hit);
    join
    `CHK("fsBab", 1'b1, hit)
    $display("test frame done");
  endtask : t_frame
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #100000;
    nFail++;
    tally_and_finish();
  end
  initial begin
    {reset_n, bitTick, armTurn, rxCrcBad, tokenSeen, hsReq} = '0;
    {frameEnd, portEnable} = '0;
    speedSel = TATR_FS;
    nFail = 0;
    nChecks = 0;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    t_timeout();
    t_start(TATR_FS);
    t_start(TATR_LS);
    t_start(TATR_HS);
    t_suppress();
    t_frame();
    tally_and_finish();
  end
endmodule : bus_turnaround_error_recovery_test
`default_nettype wire

/* testbench/tatr_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module tatr_host_model (
  input wire logic clk, // bench clock
  input wire logic lowSpeed, // ls swaps j and k
  output logic dPlus, // d+ level
  output logic dMinus, // d- level
  output logic squelch // hs squelch flag
);
  // idle watch after a corrupted fs/ls packet; beats six-bit stuff spacing
  localparam int WATCH_BITS = 16;
  initial begin
    dPlus = 1'b1;
    dMinus = 1'b0;
    squelch = 1'b1;
  end
  // line: 0 se0, 1 j, 2 k; eop is se0 then j, sop is j to k
  task automatic line(input int st, input int n);
    @(negedge clk);
    dPlus = lowSpeed ? (st == 2) : (st == 1);
    dMinus = lowSpeed ? (st == 1) : (st == 2);
    repeat (n) @(negedge clk);
  endtask : line
  // host pacing before its next token, one bit time per clock; after a
  // corrupted packet it first waits out any late talker on the bus
  task automatic token_gap(input logic bad, input logic hs,
                           input int n);
    int q;
    q = 0;
    while (bad && hs && squelch !== 1'b1) @(negedge clk);
    while (bad && !hs && q < WATCH_BITS) begin
      @(negedge clk);
      q = (dPlus !== dMinus && dPlus === !lowSpeed) ? q + 1 : 0;
    end
    repeat (n) @(negedge clk);
  endtask : token_gap
  task automatic sq(input logic v, input int n);
    @(negedge clk);
    squelch = v;
    repeat (n) @(negedge clk);
  endtask : sq
endmodule : tatr_host_model
`default_nettype wire
